// ---- hdl/gpio_input_qual_and_direction.sv ----
// Input qualification select and pin direction control with an AXI4-Lite register slave.
// Functional notes
// [R1] Each qualifiable pin has own two-bit field.
// [R2] Code 00 synchronizes input to clock only.
// [R3] Code 01 qualifies using three samples.
// [R4] Code 10 qualifies using six samples.
// [R5] Code 11 peripheral pin passes input asynchronously.
// [R6] Code 11 general-purpose input acts like 00.
// [R7] Sample spacing comes from port A period.
// [R8] Port A select: sixteen fields, pins 16-31.
// [R9] Port B select: seven fields, upper bits zero.
// [R10] Direction acts only on general-purpose pins.
// [R11] Direction 0 input by default, 1 output.
// [R12] Output pins drive their output latch value.
// [R13] Software presets latch before enabling output.
// [R14] Direction registers: 32 and 7 bits.
// [R15] Direction reads return stored setting only.
// [R16] Writes accepted only while protection permits.
// [R17] Period code 0 is one, n is 2n.
// [R18] Qualified input changes after all samples agree.
// [R19] All select and direction bits reset zero.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module gpio_input_qual_and_direction #(
   parameter int ADDR_W = 8
) (
   input  wire logic                core_clk_i,
   input  wire logic                reset_n_i,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr_i,
   input  wire logic                s_axi_awvalid_i,
   output logic                     s_axi_awready_o,
   input  wire logic [31:0]         s_axi_wdata_i,
   input  wire logic [3:0]          s_axi_wstrb_i,
   input  wire logic                s_axi_wvalid_i,
   output logic                     s_axi_wready_o,
   output logic [1:0]               s_axi_bresp_o,
   output logic                     s_axi_bvalid_o,
   input  wire logic                s_axi_bready_i,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr_i,
   input  wire logic                s_axi_arvalid_i,
   output logic                     s_axi_arready_o,
   output logic [31:0]              s_axi_rdata_o,
   output logic [1:0]               s_axi_rresp_o,
   output logic                     s_axi_rvalid_o,
   input  wire logic                s_axi_rready_i,
   input  wire logic                protected_write_permit_i,
   input  wire logic [7:0]          sample_period_field_i,
   input  wire logic [38:0]         pin_is_gpio_i,
   input  wire logic [31:0]         port_a_output_latch_i,
   input  wire logic [6:0]          port_b_output_latch_i,
   input  wire logic [22:0]         qual_pin_i,
   output logic [22:0]              qualified_o,
   output logic [38:0]              pin_oe_o,
   output logic [38:0]              pin_do_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]       qsel_a;
      logic [31:0]       qsel_b;
      logic [31:0]       dir_a;
      logic [31:0]       dir_b;
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [8:0]        period_cnt;
      logic [22:0]       sync1;
      logic [22:0]       sync2;
      logic [22:0][5:0]  samples;
      logic [22:0]       qual;
      logic [38:0]       pin_oe;
      logic [38:0]       pin_do;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Returns the qualification field of qualifiable input k.
   function automatic gpio_qual_dir_pkg::qual_mode_t qual_field(input state_t st, input int k);
      logic [1:0] f;
      if (k < gpio_qual_dir_pkg::QUAL_A_PINS) begin
         f = st.qsel_a[k*2 +: 2]; // [R1] [R8]
      end else begin
         f = st.qsel_b[(k-gpio_qual_dir_pkg::QUAL_A_PINS)*2 +: 2]; // [R1] [R9]
      end
      return gpio_qual_dir_pkg::qual_mode_t'(f);
   endfunction

   // Returns 1 when the word address matches a mapped register.
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      logic       hit;
      w   = {a[7:2], 2'b00};
      hit = 1'b0;
      case (w)
         gpio_qual_dir_pkg::QSEL_A_OFS: begin
            hit = 1'b1;
         end
         gpio_qual_dir_pkg::QSEL_B_OFS: begin
            hit = 1'b1;
         end
         gpio_qual_dir_pkg::DIR_A_OFS: begin
            hit = 1'b1;
         end
         gpio_qual_dir_pkg::DIR_B_OFS: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   // Merges byte-strobed write data into the writable bits of a register.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb, input logic [31:0] wmask);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      m = m & wmask;
      return (d & m) | (old & ~m);
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0]  wa;
      logic [7:0]  ra;
      logic        tick;
      logic [5:0]  smp;
      gpio_qual_dir_pkg::qual_mode_t mode;
      logic        agree_hi3;
      logic        agree_lo3;
      logic        agree_hi6;
      logic        agree_lo6;
      wa   = {s_r.awaddr[7:2], 2'b00};
      ra   = {s_axi_araddr_i[7:2], 2'b00};
      tick = (s_r.period_cnt == 9'h000);
      smp  = 6'h00;
      mode = gpio_qual_dir_pkg::QUAL_SYNC;
      agree_hi3 = 1'b0;
      agree_lo3 = 1'b0;
      agree_hi6 = 1'b0;
      agree_lo6 = 1'b0;
      s_nxt = s_r;

      // Write address and data are taken in either order.
      if (s_r.awready && s_axi_awvalid_i) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr_i;
      end
      if (s_r.wready && s_axi_wvalid_i) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata_i;
         s_nxt.wstrb = s_axi_wstrb_i;
      end
      if (s_r.bvalid && s_axi_bready_i) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = addr_hit(s_r.awaddr) ? gpio_qual_dir_pkg::RESP_OKAY : gpio_qual_dir_pkg::RESP_SLVERR;
         if (protected_write_permit_i) begin // [R16]
            unique case (wa)
               gpio_qual_dir_pkg::QSEL_A_OFS: begin
                  s_nxt.qsel_a = merge(s_r.qsel_a, s_r.wdata, s_r.wstrb,
                                       gpio_qual_dir_pkg::QSEL_A_WMASK); // [R8]
               end
               gpio_qual_dir_pkg::QSEL_B_OFS: begin
                  s_nxt.qsel_b = merge(s_r.qsel_b, s_r.wdata, s_r.wstrb,
                                       gpio_qual_dir_pkg::QSEL_B_WMASK); // [R9]
               end
               gpio_qual_dir_pkg::DIR_A_OFS: begin
                  s_nxt.dir_a = merge(s_r.dir_a, s_r.wdata, s_r.wstrb,
                                      gpio_qual_dir_pkg::DIR_A_WMASK); // [R14]
               end
               gpio_qual_dir_pkg::DIR_B_OFS: begin
                  s_nxt.dir_b = merge(s_r.dir_b, s_r.wdata, s_r.wstrb,
                                      gpio_qual_dir_pkg::DIR_B_WMASK); // [R14]
               end
               default: ;
            endcase
         end
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

      // Read channel answers one cycle after the address is taken.
      if (s_r.rvalid && s_axi_rready_i) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_r.arready && s_axi_arvalid_i) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = addr_hit(s_axi_araddr_i) ? gpio_qual_dir_pkg::RESP_OKAY : gpio_qual_dir_pkg::RESP_SLVERR;
         unique case (ra)
            gpio_qual_dir_pkg::QSEL_A_OFS: begin
               s_nxt.rdata = s_r.qsel_a;
            end
            gpio_qual_dir_pkg::QSEL_B_OFS: begin
               s_nxt.rdata = s_r.qsel_b & gpio_qual_dir_pkg::QSEL_B_WMASK; // [R9]
            end
            gpio_qual_dir_pkg::DIR_A_OFS: begin
               s_nxt.rdata = s_r.dir_a; // [R15]
            end
            gpio_qual_dir_pkg::DIR_B_OFS: begin
               s_nxt.rdata = s_r.dir_b & gpio_qual_dir_pkg::DIR_B_WMASK; // [R14] [R15]
            end
            default: begin
               s_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Sample period counter shared by both ports.
      if (tick) begin
         if (sample_period_field_i == 8'h00) begin
            s_nxt.period_cnt = 9'h000; // [R17]
         end else begin
            s_nxt.period_cnt = {sample_period_field_i, 1'b0} - 9'h001; // [R7] [R17]
         end
      end else begin
         s_nxt.period_cnt = s_r.period_cnt - 9'h001;
      end

      // Synchronise, sample and qualify each input.
      for (int k = 0; k < gpio_qual_dir_pkg::QUAL_PINS; k++) begin
         s_nxt.sync1[k] = qual_pin_i[k];
         s_nxt.sync2[k] = s_r.sync1[k];
         if (tick) begin
            s_nxt.samples[k] = {s_r.samples[k][4:0], s_r.sync2[k]}; // [R7]
         end
         smp  = s_r.samples[k];
         mode = qual_field(s_r, k);
         agree_hi3 = &smp[2:0];
         agree_lo3 = ~|smp[2:0];
         agree_hi6 = &smp;
         agree_lo6 = ~|smp;
         unique case (mode)
            gpio_qual_dir_pkg::QUAL_3: begin
               if (agree_hi3) begin
                  s_nxt.qual[k] = 1'b1; // [R3] [R18]
               end else if (agree_lo3) begin
                  s_nxt.qual[k] = 1'b0; // [R3] [R18]
               end
            end
            gpio_qual_dir_pkg::QUAL_6: begin
               if (agree_hi6) begin
                  s_nxt.qual[k] = 1'b1; // [R4] [R18]
               end else if (agree_lo6) begin
                  s_nxt.qual[k] = 1'b0; // [R4] [R18]
               end
            end
            gpio_qual_dir_pkg::QUAL_SYNC,
            gpio_qual_dir_pkg::QUAL_ASYNC: begin
               s_nxt.qual[k] = s_r.sync2[k]; // [R2] [R6]
            end
         endcase
      end

      // Direction applies only to pins selected as general-purpose.
      for (int p = 0; p < gpio_qual_dir_pkg::PORT_A_PINS; p++) begin
         s_nxt.pin_oe[p] = s_r.dir_a[p] & pin_is_gpio_i[p]; // [R10] [R11]
      end
      for (int p = 0; p < gpio_qual_dir_pkg::PORT_B_PINS; p++) begin
         s_nxt.pin_oe[gpio_qual_dir_pkg::PORT_A_PINS + p] = s_r.dir_b[p] &
            pin_is_gpio_i[gpio_qual_dir_pkg::PORT_A_PINS + p]; // [R10] [R11] [R14]
      end
      s_nxt.pin_do = {port_b_output_latch_i, port_a_output_latch_i}; // [R12]
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         s_r        <= '0;
         s_r.qsel_a <= gpio_qual_dir_pkg::QSEL_A_RST; // [R19]
         s_r.qsel_b <= gpio_qual_dir_pkg::QSEL_B_RST; // [R19]
         s_r.dir_a  <= gpio_qual_dir_pkg::DIR_A_RST; // [R11] [R19]
         s_r.dir_b  <= gpio_qual_dir_pkg::DIR_B_RST; // [R11] [R19]
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Peripheral pins in asynchronous mode bypass all flip-flops.
   always_comb begin
      for (int k = 0; k < gpio_qual_dir_pkg::QUAL_PINS; k++) begin
         if ((qual_field(s_r, k) == gpio_qual_dir_pkg::QUAL_ASYNC) &&
             !pin_is_gpio_i[gpio_qual_dir_pkg::QUAL_FIRST_PIN + k]) begin
            qualified_o[k] = qual_pin_i[k]; // [R5]
         end else begin
            qualified_o[k] = s_r.qual[k]; // [R6]
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus outputs
   // ----------------------------------------------------------------
   assign s_axi_awready_o = s_r.awready;
   assign s_axi_wready_o  = s_r.wready;
   assign s_axi_bvalid_o  = s_r.bvalid;
   assign s_axi_bresp_o   = s_r.bresp;
   assign s_axi_arready_o = s_r.arready;
   assign s_axi_rvalid_o  = s_r.rvalid;
   assign s_axi_rdata_o   = s_r.rdata;
   assign s_axi_rresp_o   = s_r.rresp;

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   assign pin_oe_o        = s_r.pin_oe;
   assign pin_do_o        = s_r.pin_do;

endmodule

`default_nettype wire

// ---- hdl/gpio_qual_dir_pkg.sv ----
// Shared constants for the input qualification and pin direction block.
package gpio_qual_dir_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  QSEL_A_OFS    = 8'h00;
   localparam logic [7:0]  QSEL_B_OFS    = 8'h04;
   localparam logic [7:0]  DIR_A_OFS     = 8'h08;
   localparam logic [7:0]  DIR_B_OFS     = 8'h0C;

   // ----------------------------------------------------------------
   // Reset values and writable bit masks
   // ----------------------------------------------------------------
   localparam logic [31:0] QSEL_A_RST    = 32'h0000_0000;
   localparam logic [31:0] QSEL_B_RST    = 32'h0000_0000;
   localparam logic [31:0] DIR_A_RST     = 32'h0000_0000;
   localparam logic [31:0] DIR_B_RST     = 32'h0000_0000;
   localparam logic [31:0] QSEL_A_WMASK  = 32'hFFFF_FFFF;
   localparam logic [31:0] QSEL_B_WMASK  = 32'h0000_3FFF;
   localparam logic [31:0] DIR_A_WMASK   = 32'hFFFF_FFFF;
   localparam logic [31:0] DIR_B_WMASK   = 32'h0000_007F;

   // ----------------------------------------------------------------
   // Pin counts and field layout
   // ----------------------------------------------------------------
   localparam int          PORT_A_PINS   = 32;
   localparam int          PORT_B_PINS   = 7;
   localparam int          QUAL_A_PINS   = 16;
   localparam int          QUAL_B_PINS   = 7;
   localparam int          QUAL_PINS     = QUAL_A_PINS + QUAL_B_PINS;
   localparam int          QUAL_FIRST_PIN = 16;
   localparam int          QSEL_FIELD_W  = 2;

   // ----------------------------------------------------------------
   // Qualification modes and sample counts
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      QUAL_SYNC  = 2'b00,
      QUAL_3     = 2'b01,
      QUAL_6     = 2'b10,
      QUAL_ASYNC = 2'b11
   } qual_mode_t;
   localparam int          QUAL_3_SAMPLES = 3;
   localparam int          QUAL_6_SAMPLES = 6;
   localparam int          PERIOD_W       = 8;
   localparam int          PERIOD_CNT_W   = 9;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;

endpackage

// ---- verif/pin_side_model.sv ----
// Far-side model that drives the raw pin levels seen by the block.
`timescale 1ns/10ps
`default_nettype none
module pin_side_model (
   input  wire logic        core_clk_i,
   output var  logic [22:0] pin_o
);
   initial pin_o = 23'h000000;
   task drive(input int k, input logic v);
      @(posedge core_clk_i);
      pin_o[k] <= v;
   endtask
   task pulse(input int k, input int n);
      drive(k, 1'b1);
      repeat (n) @(posedge core_clk_i);
      pin_o[k] <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- verif/gpio_input_qual_and_direction_checker.sv ----
// Port checks for the qualification and direction block.
`timescale 1ns/10ps
`default_nettype none
module gpio_input_qual_and_direction_checker (
   input wire logic        core_clk_i,
   input wire logic        reset_n_i,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [38:0] pin_is_gpio_i,
   input wire logic [31:0] port_a_output_latch_i,
   input wire logic [6:0]  port_b_output_latch_i,
   input wire logic [22:0] qual_pin_i,
   input wire logic [22:0] qualified_o,
   input wire logic [38:0] pin_oe_o,
   input wire logic [38:0] pin_do_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   a_b_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response not held");
   a_r_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data not held");
   a_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address taken while data pending");
   a_oe_gpio: assert property ((pin_oe_o & ~$past(pin_is_gpio_i)) == 39'h0)
      else $error("output enabled on a peripheral pin");
   a_oe_reset: assert property ($rose(reset_n_i) |-> pin_oe_o == 39'h0)
      else $error("output enabled after reset");
   a_do_latch: assert property ($past(reset_n_i) |->
      pin_do_o == {$past(port_b_output_latch_i), $past(port_a_output_latch_i)}) else $error("pin data not latch");
   a_qual_rise: assert property ((qualified_o & ~$past(qualified_o) & ~qual_pin_i & ~$past(qual_pin_i, 3)) == 23'h0)
      else $error("qualified input rose without pin");
endmodule
bind gpio_input_qual_and_direction gpio_input_qual_and_direction_checker u_chk (.core_clk_i, .reset_n_i,
   .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .s_axi_rdata_o, .pin_is_gpio_i, .port_a_output_latch_i, .port_b_output_latch_i,
   .qual_pin_i, .qualified_o, .pin_oe_o, .pin_do_o);
`default_nettype wire

// ---- verif/gpio_input_qual_and_direction_bench.sv ----
// Self-checking bench for the qualification and direction block.
`timescale 1ns/10ps
`default_nettype none
module gpio_input_qual_and_direction_bench;
   localparam logic [1:0]  OK = gpio_qual_dir_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR = gpio_qual_dir_pkg::RESP_SLVERR;
   localparam logic [7:0]  OFS [4] = '{gpio_qual_dir_pkg::QSEL_A_OFS, gpio_qual_dir_pkg::QSEL_B_OFS,
                                       gpio_qual_dir_pkg::DIR_A_OFS, gpio_qual_dir_pkg::DIR_B_OFS};
   localparam logic [31:0] MSK [4] = '{32'hFFFF_FFFF, 32'h0000_3FFF, 32'hFFFF_FFFF, 32'h0000_007F};
   localparam logic [31:0] QV [8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'hC000_0000, 32'h1, 32'h2, 32'h1};
   localparam logic [7:0]  PR [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
   localparam int          K [8] = '{0, 0, 0, 0, 15, 0, 0, 16};
   localparam int          PL [8] = '{0, 0, 0, 0, 0, 2, 5, 0};
   localparam int          LO [8] = '{3, 6, 9, 3, 0, 40, 40, 12};
   localparam int          HI [8] = '{3, 6, 9, 3, 0, 40, 40, 15};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, permit = 1'b1;
   logic        awr, wr, bv, arr, rv;
   logic [1:0]  bresp, rresp;
   logic [7:0]  awa = 8'h00, ara = 8'h00, prd = 8'h00;
   logic [31:0] wd = 32'h0, la = 32'h0, rdata;
   logic [6:0]  lb = 7'h00;
   logic [38:0] gpio = 39'h0, oe, dout;
   logic [22:0] pin, q;
   int          num_errors = 0, checks_done = 0, n;
   always #5 clk = ~clk;
   pin_side_model far (.core_clk_i(clk), .pin_o(pin));
   gpio_input_qual_and_direction dut (.core_clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
      .protected_write_permit_i(permit), .sample_period_field_i(prd), .pin_is_gpio_i(gpio),
      .port_a_output_latch_i(la), .port_b_output_latch_i(lb), .qual_pin_i(pin), .qualified_o(q),
      .pin_oe_o(oe), .pin_do_o(dout));
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string s, input logic [38:0] e, input logic [38:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      logic [1:0] rs;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         ha = awv & awr;
         hw = wv & wr;
         hb = bv;
         rs = bresp;
         @(posedge clk);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
         if (hb) break;
      end
      br <= 1'b0;
      chk("bvalid", 39'h1, 39'(hb));
      chk("bresp", 39'(er), 39'(rs));
   endtask
   task automatic rd32(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ha, hr;
      logic [31:0] d;
      logic [1:0] rs;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         ha = arv & arr;
         hr = rv;
         d = rdata;
         rs = rresp;
         @(posedge clk);
         if (ha) arv <= 1'b0;
         if (hr) break;
      end
      rr <= 1'b0;
      chk("rvalid", 39'h1, 39'(hr));
      chk("rdata", 39'(e), 39'(d));
      chk("rresp", 39'(er), 39'(rs));
   endtask
   task automatic lat(input int k, input logic v, output int c);
      for (c = 0; c < 40; c++) begin
         @(negedge clk);
         if (q[k] === v) break;
      end
      @(posedge clk);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) rd32(OFS[i], 32'h0, OK);
      rd32(8'h10, 32'h0, ERR);
      wr32(8'h10, 32'hFFFF_FFFF, ERR);
      for (int i = 0; i < 4; i++) begin
         wr32(OFS[i], 32'hFFFF_FFFF, OK);
         rd32(OFS[i], MSK[i], OK);
         permit <= 1'b0;
         wr32(OFS[i], 32'h0, OK);
         rd32(OFS[i], MSK[i], OK);
         permit <= 1'b1;
         wr32(OFS[i], 32'h0, OK);
      end
      la <= 32'hC3A5_5A3C;
      lb <= 7'h2B;
      gpio <= 39'h7F_FFFF_0FF0;
      wr32(OFS[2], 32'hF0F0_A5A5, OK);
      wr32(OFS[3], 32'h0000_0055, OK);
      @(negedge clk);
      chk("pin_oe", 39'h55_F0F0_A5A5 & 39'h7F_FFFF_0FF0, oe);
      chk("pin_do", 39'h2B_C3A5_5A3C, dout);
      rd32(OFS[2], 32'hF0F0_A5A5, OK);
      gpio <= 39'h7F_7FFF_FFFF;
      for (int i = 0; i < 8; i++) begin
         prd <= PR[i];
         wr32(K[i] < 16 ? OFS[0] : OFS[1], QV[i], OK);
         if (PL[i] > 0) far.pulse(K[i], PL[i]);
         else far.drive(K[i], 1'b1);
         lat(K[i], 1'b1, n);
         chk("latency", 39'(LO[i]), 39'((n >= LO[i] && n <= HI[i]) ? LO[i] : n));
         far.drive(K[i], 1'b0);
         lat(K[i], 1'b0, n);
      end
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd32(OFS[3], 32'h0, OK);
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done();
   end
endmodule
`default_nettype wire
